// >>> rtl/slc_counter.sv
// Programmable tick counter: free-running divider or one-shot slot timer.
// Assumes tick and start are synchronous to clk; limit may change at any time.

module slc_counter
    import slc_pkg::*;
#(
    parameter int W        = 9,
    parameter bit ONE_SHOT = 1'b0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         start,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    // Status
    output logic              busy,
    output logic              done,
    output logic              level
);

    localparam logic [W-1:0] ONE = W'(1);

    logic [W-1:0] cnt_ff;
    logic         busy_ff;
    logic         done_ff;
    logic         level_ff;

    wire          active   = ONE_SHOT ? busy_ff : 1'b1;
    wire          step     = tick & active;
    wire          last     = step & (cnt_ff >= limit);
    wire          restart  = ONE_SHOT & start;
    wire [W-1:0]  nxt_cnt  = restart ? ONE : (last ? ONE : (step ? cnt_ff + ONE : cnt_ff));
    // A fresh start wins over the slot ending in the same cycle
    wire          nxt_busy = ONE_SHOT ? (restart | (busy_ff & ~last)) : 1'b1;
    wire          nxt_done = last & ~restart;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff   <= ONE;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            busy_ff  <= nxt_busy;
            done_ff  <= nxt_done;
            level_ff <= level_ff ^ nxt_done;
        end
    end

    assign busy  = busy_ff;
    assign done  = done_ff;
    assign level = level_ff;

endmodule

// >>> rtl/slc_pkg.sv
// Constants, field layout and encodings of the synthesizer configuration registers.
// Assumes a single ref_clk domain; all pins are synchronised by the user of this package.
//
// What this block does
// - Low-power bits 4, 2, 0: output buffer, demux, reference buffer; 1 = low.
// - Calibration register bit 26 set applies dithering to modulator output.
// - Bits 23:22 pick modulator order: 00 third, 01 second, 10 first, 11 fourth.
// - Bit 20 enables calibration auto-restart; some variants need it kept zero.
// - Bits 19:18 choose oscillator from lowest to highest, test use only.
// - Bits 17:13 select one oscillator sub-band, 0 to 31, test use only.
// - Bit 12 enables temperature compensation of calibration.
// - Bits 11:10 give pre-charge slots as code plus one, 1 to 4.
// - Bit 9 set adds two calibration slots for accuracy; default zero.
// - Bits 8:0 divide calibrator clock by 1 to 511; zero means 511.
// - Output register bit 25 set puts shared lock/read pin in high impedance.
// - Bit 24 picks shared pin driver: 0 open-drain, 1 push-pull.
// - Bit 23 clear gives read data on shared pin in reads; set blocks reads.
// - Bits 22:21 pick pin source: lock, oscillator divider, calibrator divider, quick clock.
// - Bit 19 set enables cycle-slip feature, clear keeps it off.
// - Bit 18 set enables quick acquire using the shared switch pin.
// - Bits 17:13 give pump current code used only during quick acquire slot.
// - Bits 12:0 give quick acquire slot length in detector cycles, 1 to 8191.
// - Lock indicator high when locked if polarity zero, low when locked if one.

package slc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame: read flag, four address bits, then data MSB first
    localparam int         REG_W        = 27;
    localparam int         ADDR_W       = 4;
    localparam logic [5:0] HDR_LEN      = 6'h05;
    localparam logic [5:0] FRAME_LEN    = 6'h20;
    localparam int         SYNC_N       = 8;

    localparam logic [ADDR_W-1:0] ADDR_LOW_POWER = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_CAL_MOD   = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_FAST_PIN  = 4'h7;

    localparam logic [REG_W-1:0] REG_RESET  = 27'h0000000;

    ////////////////////////////////////////////////////////////////////////////
    // Low-power control fields
    localparam int LP_OUTBUF = 4;
    localparam int LP_DEMUX  = 2;
    localparam int LP_REFBUF = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Calibration and modulator fields
    localparam int CM_DITHER   = 26;
    localparam int CM_SRC_OFF  = 25;
    localparam int CM_SNK_OFF  = 24;
    localparam int CM_ORD_HI   = 23;
    localparam int CM_ORD_LO   = 22;
    localparam int CM_AUTO     = 20;
    localparam int CM_OSC_HI   = 19;
    localparam int CM_OSC_LO   = 18;
    localparam int CM_SUB_HI   = 17;
    localparam int CM_SUB_LO   = 13;
    localparam int CM_TEMP     = 12;
    localparam int CM_PRE_HI   = 11;
    localparam int CM_PRE_LO   = 10;
    localparam int CM_ACC      = 9;
    localparam int CM_DIV_HI   = 8;
    localparam int CM_DIV_LO   = 0;

    localparam logic [8:0] CAL_DIV_MAX  = 9'h1FF;
    localparam logic [8:0] CAL_DIV_ZERO = 9'h000;
    localparam logic [1:0] EXTRA_SLOTS  = 2'h2;
    localparam logic [1:0] NO_SLOTS     = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Quick acquire and shared pin fields
    localparam int FP_HIZ      = 25;
    localparam int FP_DRIVE    = 24;
    localparam int FP_RD_OFF   = 23;
    localparam int FP_SEL_HI   = 22;
    localparam int FP_SEL_LO   = 21;
    localparam int FP_PROT_OFF = 20;
    localparam int FP_SLIP     = 19;
    localparam int FP_QA_EN    = 18;
    localparam int FP_CUR_HI   = 17;
    localparam int FP_CUR_LO   = 13;
    localparam int FP_DUR_HI   = 12;
    localparam int FP_DUR_LO   = 0;

    typedef enum logic [1:0] {
        ORDER_THIRD  = 2'h0,
        ORDER_SECOND = 2'h1,
        ORDER_FIRST  = 2'h2,
        ORDER_FOURTH = 2'h3
    } slc_order_t;

    typedef enum logic [1:0] {
        PIN_LOCK    = 2'h0,
        PIN_OSC_DIV = 2'h1,
        PIN_CAL_DIV = 2'h2,
        PIN_QA_CLK  = 2'h3
    } slc_pin_src_t;

    // Dither sequence seed, any non-zero value works
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

endpackage

// >>> rtl/slc_regs.sv
// Configuration registers for low power, calibration, modulator and quick acquire.
// Assumes the serial host pins and monitored signals arrive asynchronously to ref_clk.

module slc_regs
    import slc_pkg::*;
#(
    parameter int DIV_W = 9,
    parameter int DUR_W = 13
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // Serial host pins
    input  wire logic             serialClk,
    input  wire logic             serialDataIn,
    input  wire logic             serialSelectN,
    // Shared lock / read data pin
    output logic                  lockOrReadDataPinOut,
    output logic                  lockOrReadDataPinOeN,
    // Monitored signals
    input  wire logic             lockRaw,
    input  wire logic             oscDividerClk,
    input  wire logic             detectorClk,
    input  wire logic             lockIndicatorPolarity,
    input  wire logic             quickAcquireTrigger,
    // Low power controls
    output logic                  secondOutputBufferLowPower,
    output logic                  outputDemultiplexerLowPower,
    output logic                  referenceBufferLowPower,
    // Calibration and modulator controls
    output logic                  pumpSourceTestOff,
    output logic                  pumpSinkTestOff,
    output logic [1:0]            modulatorOrder,
    output logic                  ditherBit,
    output logic                  calibrationAutoRestart,
    output logic [1:0]            oscillatorSelect,
    output logic [4:0]            oscillatorSubband,
    output logic                  tempCompEnable,
    output logic [2:0]            tuningPrechargeSlots,
    output logic [1:0]            calibrationExtraSlots,
    output logic                  calibratorTick,
    // Quick acquire and cycle slip controls
    output logic                  cycleSlipEnable,
    output logic                  digitalRegulatorProtectionOff,
    output logic                  quickAcquireActive,
    output logic [4:0]            quickAcquirePumpCurrent,
    output logic                  secondOutputOffOrQuickSwitchPin
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [SYNC_N-1:0] syncA_ff;
    logic [SYNC_N-1:0] syncB_ff;
    logic              sclkPrev_ff;
    logic              csnPrev_ff;
    logic              detPrev_ff;
    logic              trigPrev_ff;

    wire [SYNC_N-1:0]  pinRaw = {1'b0, quickAcquireTrigger, lockIndicatorPolarity, detectorClk,
                                 oscDividerClk, lockRaw, serialDataIn, serialClk};
    wire               sclkS  = syncB_ff[0];
    wire               sdiS   = syncB_ff[1];
    wire               lockS  = syncB_ff[2];
    wire               oscS   = syncB_ff[3];
    wire               detS   = syncB_ff[4];
    wire               polS   = syncB_ff[5];
    wire               trigS  = syncB_ff[6];

    // Select idles high so it needs its own reset value
    logic              csnA_ff;
    logic              csnS;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
            csnA_ff  <= 1'b1;
            csnS     <= 1'b1;
        end else begin
            syncA_ff <= pinRaw;
            syncB_ff <= syncA_ff;
            csnA_ff  <= serialSelectN;
            csnS     <= csnA_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclkPrev_ff <= 1'b0;
            csnPrev_ff  <= 1'b1;
            detPrev_ff  <= 1'b0;
            trigPrev_ff <= 1'b0;
        end else begin
            sclkPrev_ff <= sclkS;
            csnPrev_ff  <= csnS;
            detPrev_ff  <= detS;
            trigPrev_ff <= trigS;
        end
    end

    wire sclkRise = sclkS & ~sclkPrev_ff & ~csnS;
    wire sclkFall = ~sclkS & sclkPrev_ff & ~csnS;
    wire csnRise  = csnS & ~csnPrev_ff;
    wire detRise  = detS & ~detPrev_ff;
    wire trigRise = trigS & ~trigPrev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame shifter
    logic [31:0]      shiftIn_ff;
    logic [5:0]       bitCnt_ff;
    logic             reading_ff;
    logic [REG_W-1:0] readShift_ff;
    logic [REG_W-1:0] lowPower_ff;
    logic [REG_W-1:0] calMod_ff;
    logic [REG_W-1:0] fastPin_ff;

    wire [ADDR_W-1:0] rdAddr     = {shiftIn_ff[2:0], sdiS};
    wire              rdStart    = sclkRise & (bitCnt_ff == HDR_LEN - 6'h01) & shiftIn_ff[3];
    // Reads are refused while the read-off bit FP_RD_OFF (bit 23) is set
    wire              rdAllowed  = ~fastPin_ff[FP_RD_OFF];
    wire [REG_W-1:0]  rdValue    = (rdAddr == ADDR_LOW_POWER) ? lowPower_ff :
                                   (rdAddr == ADDR_CAL_MOD)   ? calMod_ff   :
                                   (rdAddr == ADDR_FAST_PIN)  ? fastPin_ff  : REG_RESET;
    wire [5:0]        nxt_bitCnt = csnS ? 6'h00 :
                                   (sclkRise && bitCnt_ff != FRAME_LEN) ? bitCnt_ff + 6'h01 : bitCnt_ff;
    wire              shiftOut   = sclkFall & reading_ff & (bitCnt_ff > HDR_LEN);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shiftIn_ff   <= 32'h00000000;
            bitCnt_ff    <= 6'h00;
            reading_ff   <= 1'b0;
            readShift_ff <= REG_RESET;
        end else begin
            shiftIn_ff   <= sclkRise ? {shiftIn_ff[30:0], sdiS} : shiftIn_ff;
            bitCnt_ff    <= nxt_bitCnt;
            reading_ff   <= csnS ? 1'b0 : (reading_ff | (rdStart & rdAllowed));
            readShift_ff <= rdStart ? rdValue : (shiftOut ? {readShift_ff[REG_W-2:0], 1'b0} : readShift_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register write decode
    wire              frameDone = csnRise & (bitCnt_ff == FRAME_LEN) & ~shiftIn_ff[31];
    wire [ADDR_W-1:0] wrAddr    = shiftIn_ff[30:27];
    wire [REG_W-1:0]  wrData    = shiftIn_ff[REG_W-1:0];
    wire              writeLp   = frameDone & (wrAddr == ADDR_LOW_POWER);
    wire              writeCal  = frameDone & (wrAddr == ADDR_CAL_MOD);
    wire              writeFast = frameDone & (wrAddr == ADDR_FAST_PIN);

    wire [REG_W-1:0]  nxt_lowPower = writeLp   ? wrData : lowPower_ff;
    wire [REG_W-1:0]  nxt_calMod   = writeCal  ? wrData : calMod_ff;
    wire [REG_W-1:0]  nxt_fastPin  = writeFast ? wrData : fastPin_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lowPower_ff <= REG_RESET;
            calMod_ff   <= REG_RESET;
            fastPin_ff  <= REG_RESET;
        end else begin
            lowPower_ff <= nxt_lowPower;
            calMod_ff   <= nxt_calMod;
            fastPin_ff  <= nxt_fastPin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration and modulator derived controls
    logic [15:0]      lfsr_ff;
    logic             dither_ff;
    logic [DIV_W-1:0] calDivEff_ff;
    logic [2:0]       precharge_ff;
    logic [1:0]       extraSlots_ff;

    wire [DIV_W-1:0]  calDivField  = calMod_ff[CM_DIV_HI:CM_DIV_LO];
    wire [1:0]        preField     = calMod_ff[CM_PRE_HI:CM_PRE_LO];
    wire [DIV_W-1:0]  nxt_calDiv   = (calDivField == CAL_DIV_ZERO) ? CAL_DIV_MAX : calDivField;
    wire [2:0]        nxt_pre      = {1'b0, preField} + 3'h1;
    wire [1:0]        nxt_extra    = calMod_ff[CM_ACC] ? EXTRA_SLOTS : NO_SLOTS;
    wire [15:0]       nxt_lfsr     = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    wire              nxt_dither   = calMod_ff[CM_DITHER] & lfsr_ff[0];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lfsr_ff       <= LFSR_SEED;
            dither_ff     <= 1'b0;
            calDivEff_ff  <= CAL_DIV_MAX;
            precharge_ff  <= 3'h1;
            extraSlots_ff <= NO_SLOTS;
        end else begin
            lfsr_ff       <= nxt_lfsr;
            dither_ff     <= nxt_dither;
            calDivEff_ff  <= nxt_calDiv;
            precharge_ff  <= nxt_pre;
            extraSlots_ff <= nxt_extra;
        end
    end

    logic calDone;
    logic calLevel;
    slc_counter #(.W(DIV_W), .ONE_SHOT(1'b0)) calDivider (
        .clk   (ref_clk),
        .rstn  (rstn),
        .start (1'b0),
        .tick  (1'b1),
        .limit (calDivEff_ff),
        .busy  (),
        .done  (calDone),
        .level (calLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Quick acquire slot timer, counted in detector clock cycles
    logic qaBusy;
    wire  qaStart = trigRise & fastPin_ff[FP_QA_EN];

    slc_counter #(.W(DUR_W), .ONE_SHOT(1'b1)) quickSlot (
        .clk   (ref_clk),
        .rstn  (rstn),
        .start (qaStart),
        .tick  (detRise),
        .limit (fastPin_ff[FP_DUR_HI:FP_DUR_LO]),
        .busy  (qaBusy),
        .done  (),
        .level ()
    );

    logic       qaActive_ff;
    logic [4:0] qaCurrent_ff;
    logic       qaSwitch_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            qaActive_ff  <= 1'b0;
            qaCurrent_ff <= 5'h00;
            qaSwitch_ff  <= 1'b0;
        end else begin
            qaActive_ff  <= qaBusy;
            qaCurrent_ff <= qaBusy ? fastPin_ff[FP_CUR_HI:FP_CUR_LO] : 5'h00;
            qaSwitch_ff  <= qaBusy & fastPin_ff[FP_QA_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin: source select, read override, driver type
    logic pinOut_ff;
    logic pinOeN_ff;

    wire  lockShown = lockS ^ polS;
    wire [1:0] pinSel = fastPin_ff[FP_SEL_HI:FP_SEL_LO];
    wire  srcValue  = (pinSel == PIN_LOCK)    ? lockShown :
                      (pinSel == PIN_OSC_DIV) ? oscS      :
                      (pinSel == PIN_CAL_DIV) ? calLevel  : detS;
    wire  readMode  = reading_ff & rdAllowed & ~csnS;
    wire  pinValue  = readMode ? readShift_ff[REG_W-1] : srcValue;
    wire  hiZ       = fastPin_ff[FP_HIZ];
    wire  pushPull  = fastPin_ff[FP_DRIVE];
    // open-drain drives only the low level
    wire  nxt_oeN   = hiZ | (~pushPull & pinValue);
    wire  nxt_out   = ~hiZ & pushPull & pinValue;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinOut_ff <= 1'b0;
            pinOeN_ff <= 1'b1;
        end else begin
            pinOut_ff <= nxt_out;
            pinOeN_ff <= nxt_oeN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign lockOrReadDataPinOut            = pinOut_ff;
    assign lockOrReadDataPinOeN            = pinOeN_ff;
    assign secondOutputBufferLowPower      = lowPower_ff[LP_OUTBUF];
    assign outputDemultiplexerLowPower     = lowPower_ff[LP_DEMUX];
    assign referenceBufferLowPower         = lowPower_ff[LP_REFBUF];
    assign pumpSourceTestOff               = calMod_ff[CM_SRC_OFF];
    assign pumpSinkTestOff                 = calMod_ff[CM_SNK_OFF];
    assign modulatorOrder                  = calMod_ff[CM_ORD_HI:CM_ORD_LO];
    assign ditherBit                       = dither_ff;
    assign calibrationAutoRestart          = calMod_ff[CM_AUTO];
    assign oscillatorSelect                = calMod_ff[CM_OSC_HI:CM_OSC_LO];
    assign oscillatorSubband               = calMod_ff[CM_SUB_HI:CM_SUB_LO];
    assign tempCompEnable                  = calMod_ff[CM_TEMP];
    assign tuningPrechargeSlots            = precharge_ff;
    assign calibrationExtraSlots           = extraSlots_ff;
    assign calibratorTick                  = calDone;
    assign cycleSlipEnable                 = fastPin_ff[FP_SLIP];
    // Stored and passed on; host keeps it zero
    assign digitalRegulatorProtectionOff   = fastPin_ff[FP_PROT_OFF];
    assign quickAcquireActive              = qaActive_ff;
    assign quickAcquirePumpCurrent         = qaCurrent_ff;
    assign secondOutputOffOrQuickSwitchPin = qaSwitch_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    lp_outbuf_a: assert property (writeLp |=> secondOutputBufferLowPower == $past(wrData[LP_OUTBUF]))
        else $error("low power bit not taken from write");
    dither_off_a: assert property (!calMod_ff[CM_DITHER] |=> !ditherBit)
        else $error("dither active while disabled");
    order_write_a: assert property (writeCal |=> ##1 modulatorOrder == $past(wrData[CM_ORD_HI:CM_ORD_LO], 2))
        else $error("modulator order not taken from write");
    precharge_a: assert property (##1 tuningPrechargeSlots == {1'b0, $past(preField)} + 3'h1)
        else $error("precharge slot count wrong");
    extra_slots_a: assert property (calMod_ff[CM_ACC] |=> calibrationExtraSlots == EXTRA_SLOTS)
        else $error("extra slots missing");
    cal_div_zero_a: assert property (calDivField == CAL_DIV_ZERO |=> calDivEff_ff == CAL_DIV_MAX)
        else $error("zero divider not mapped to max");
    pin_hiz_a: assert property (hiZ |=> lockOrReadDataPinOeN && !lockOrReadDataPinOut)
        else $error("shared pin driven in high impedance");
    open_drain_a: assert property (!hiZ && !pushPull |=> !lockOrReadDataPinOut)
        else $error("open drain drove high");
    read_data_a: assert property (readMode && pushPull && !hiZ |=> lockOrReadDataPinOut == $past(readShift_ff[REG_W-1]))
        else $error("read data not on shared pin");
    lock_pol_a: assert property (!readMode && !hiZ && pushPull && pinSel == PIN_LOCK && lockS == polS
                                 |=> !lockOrReadDataPinOut)
        else $error("lock polarity wrong");
    quick_current_a: assert property (!qaBusy |=> quickAcquirePumpCurrent == 5'h00)
        else $error("quick current outside slot");

endmodule

// >>> testbench/slc_host.sv
// Serial host model that sends register frames.
// Assumes it is called at a falling clk edge; the bench resolves the shared pin.
module slc_host (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sClkPin  = 1'b0,
    output logic      sDataPin = 1'b0,
    output logic      sSelN    = 1'b1,
    input  wire logic sReadPin
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // reads sampled on rises
    task automatic frame(input logic rd, input logic [3:0] a, input logic [26:0] d, output logic [26:0] q);
        logic [31:0] w;
        w = {rd, a, d};
        q = 27'h0;
        sSelN = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            sDataPin = w[i];
            repeat (5) @(negedge clk);
            if (i < 27) q[i] = sReadPin;
            sClkPin = 1'b1;
            repeat (5) @(negedge clk);
            sClkPin = 1'b0;
        end
        repeat (5) @(negedge clk);
        sSelN = 1'b1;
        // Released line shows no stale bit
        sDataPin = ~sDataPin;
        repeat (8) @(negedge clk);
    endtask
endmodule

// >>> testbench/tb_top.sv
// Bench for the configuration registers.
// Assumes slc_host paces frames; the shared pin has a pull-up.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import slc_pkg::*;
    logic ref_clk, rstn, serialClk, serialDataIn, serialSelectN, lockRaw, lockIndicatorPolarity, pin;
    logic oscDividerClk, detectorClk = 1'b0, quickAcquireTrigger, lockOrReadDataPinOut, lockOrReadDataPinOeN;
    logic secondOutputBufferLowPower, outputDemultiplexerLowPower, referenceBufferLowPower, pumpSourceTestOff;
    logic pumpSinkTestOff, ditherBit, calibrationAutoRestart, tempCompEnable, calibratorTick, cycleSlipEnable;
    logic digitalRegulatorProtectionOff, quickAcquireActive, secondOutputOffOrQuickSwitchPin;
    logic [1:0]  modulatorOrder, oscillatorSelect, calibrationExtraSlots;
    logic [4:0]  oscillatorSubband, quickAcquirePumpCurrent;
    logic [2:0]  tuningPrechargeSlots;
    logic [26:0] q, w;
    int          nErrors, checks, c;
    assign pin = lockOrReadDataPinOeN ? 1'b1 : lockOrReadDataPinOut;
    assign oscDividerClk = ~detectorClk;
    slc_regs slc_regs_i (.*);
    slc_host slc_host_i (.clk(ref_clk), .sClkPin(serialClk), .sDataPin(serialDataIn), .sSelN(serialSelectN),
        .sReadPin(pin));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) detectorClk <= ~detectorClk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [26:0] e, input logic [26:0] g);
        checks++;
        if (g !== e) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [26:0] e);
        slc_host_i.frame(1'b1, a, 27'h0, q);
        chk("read", e, q);
    endtask
    task automatic wr(input logic [3:0] a, input logic [26:0] d);
        slc_host_i.frame(1'b0, a, d, q);
    endtask
    task automatic period(input logic [26:0] n);
        repeat (2) @(posedge calibratorTick);
        @(negedge ref_clk);
        c = 0;
        do begin
            @(negedge ref_clk);
            c++;
        end while (calibratorTick !== 1'b1 && c < 600);
        chk("tick period", n, 27'(c));
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        nErrors++;
        report_and_stop;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, lockIndicatorPolarity, quickAcquireTrigger, lockRaw} = 4'h1;
        repeat (8) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("reset", 27'h9, {tuningPrechargeSlots, calibrationExtraSlots, lockOrReadDataPinOeN});
        wr(ADDR_LOW_POWER, 27'h0000015);
        chk("low power", 27'h7, {secondOutputBufferLowPower, outputDemultiplexerLowPower, referenceBufferLowPower});
        rd(ADDR_LOW_POWER, 27'h0000015);
        $display("test low power done");
        w = {1'b1, 2'h0, 2'h3, 1'b0, 1'b1, 2'h2, 5'h1F, 1'b1, 2'h3, 1'b1, 9'h000};
        wr(ADDR_CAL_MOD, w);
        chk("cal", {2'h3, 2'h2, 5'h1F, 2'h3, 3'h4, 2'h2}, {modulatorOrder, oscillatorSelect, oscillatorSubband,
            tempCompEnable, calibrationAutoRestart, tuningPrechargeSlots, calibrationExtraSlots});
        c = 0;
        repeat (32) @(negedge ref_clk) c += int'(ditherBit);
        chk("dither", 27'h1, 27'(c > 0 && c < 32));
        period(27'h1FF);
        rd(ADDR_CAL_MOD, w);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CAL_MOD, {3'h0, 2'(i), 13'h0000, 9'h003});
            chk("order", 27'(i), 27'(modulatorOrder));
        end
        chk("cal off", 27'h4, {pumpSourceTestOff, pumpSinkTestOff, ditherBit, tuningPrechargeSlots,
            calibrationExtraSlots});
        period(27'h003);
        $display("test calibration done");
        wr(ADDR_FAST_PIN, 27'h1000000);
        chk("pin", 27'h2, {pin, lockOrReadDataPinOeN});
        lockIndicatorPolarity = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("pin", 27'h0, {pin, lockOrReadDataPinOeN});
        wr(ADDR_FAST_PIN, 27'h1800000);
        rd(ADDR_FAST_PIN, 27'h0);
        lockIndicatorPolarity = 1'b0;
        // Oscillator, calibrator and detector sources all toggle, lock does not
        for (int s = 1; s < 4; s++) begin
            wr(ADDR_FAST_PIN, 27'(s) << 21);
            c = 0;
            repeat (8) begin
                w[0] = pin;
                @(negedge ref_clk);
                c += int'(w[0] !== pin);
            end
            chk("pin source", 27'h1, 27'(c > 0));
        end
        wr(ADDR_FAST_PIN, 27'h3200000);
        chk("pin", 27'h3, {pin, lockOrReadDataPinOeN});
        wr(ADDR_FAST_PIN, 27'h1000000);
        rd(ADDR_FAST_PIN, 27'h1000000);
        wr(4'h3, 27'h0000004);
        rd(4'h3, 27'h0);
        rd(ADDR_LOW_POWER, 27'h0000015);
        $display("test shared pin done");
        wr(ADDR_FAST_PIN, 27'h00FE014);
        chk("slip", 27'h1, 27'({digitalRegulatorProtectionOff, cycleSlipEnable}));
        quickAcquireTrigger = 1'b1;
        for (c = 0; quickAcquireActive !== 1'b1 && c < 20; c++) @(negedge ref_clk);
        repeat (2) @(negedge ref_clk);
        chk("slot", 27'h7F, {quickAcquireActive, quickAcquirePumpCurrent, secondOutputOffOrQuickSwitchPin});
        for (c = 0; quickAcquireActive === 1'b1 && c < 100; c++) @(negedge ref_clk);
        chk("slot length", 27'h1, 27'(c > 34 && c < 42));
        repeat (2) @(negedge ref_clk);
        chk("after slot", 27'h0, {quickAcquirePumpCurrent, secondOutputOffOrQuickSwitchPin});
        $display("test quick acquire done");
        report_and_stop;
    end
endmodule
